// ==== design/tod_drift_pkg.sv ====
/*
  constants for the time-of-day drift correction block: register offsets,
  field positions, reset values.
  assumes a single AHB-Lite master and 32-bit word access.
*/
`default_nettype none
package tod_drift_pkg;
  localparam logic [7:0] amount_offset = 8'h1c;
  localparam logic [7:0] interval_offset = 8'h20;
  localparam logic [7:0] period_offset = 8'h10;
  localparam int frac_lsb = 0;
  localparam int frac_msb = 15;
  localparam int whole_lsb = 16;
  localparam int whole_msb = 19;
  localparam int rate_msb = 15;
  localparam logic [31:0] amount_reset = 32'h0000_0000;
  localparam logic [31:0] interval_reset = 32'h0000_0000;
  localparam logic [19:0] period_reset = 20'h0_0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_one = 16'h0001;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  localparam int tod_width = 64;
  localparam logic [7:0] addr_reset = 8'h00;
  localparam logic [31:0] read_zero = 32'h0000_0000;
  localparam logic [63:0] tod_reset = 64'h0000_0000_0000_0000;
  localparam logic ready_idle = 1'h1;
  localparam logic resp_okay = 1'h0;
  localparam logic pulse_reset = 1'h0;
endpackage
`default_nettype wire

// ==== design/tod_drift_adjust.sv ====
/*
  drift-correcting time-of-day counter with an AHB-Lite register slave.
  assumes hclk is the time-of-day period clock and that the one master
  issues only single word transfers.
*/
// What this block does
// - each correction adds amount bits 15:0 as fractional nanoseconds to the time.
// - each correction also adds amount bits 19:16 as whole nanoseconds.
// - amount bits 20 and up are unused and never affect the time.
// - a correction is applied once after every interval of rate bits 15:0 cycles.
// - rate register bits 16 and up are ignored.
// - reset clears amount and rate registers to zero, so nothing is added.
// - period fraction holds only integer part of scaled fraction; remainder dropped.
// - period increment: fraction in bits 15:0, whole ns in bits 19:16, each clock.
`timescale 1ns/1ns
`default_nettype none
module tod_drift_adjust
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // time value
  output logic [63:0] time_of_day,
  output logic correction_applied
);

  // one-hot bus phase; an illegal code falls back to idle
  typedef enum logic [2:0]
  {
    phase_idle = 3'h1,
    phase_write = 3'h2,
    phase_read = 3'h4
  } bus_phase_t;

  bus_phase_t phase_q, phase_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q, hresp_d;
  logic [31:0] amount_q, amount_d;
  logic [31:0] interval_q, interval_d;
  logic [19:0] period_q, period_d;
  logic [15:0] count_q, count_d;
  logic [63:0] tod_q, tod_d;
  logic applied_q, applied_d;
  logic [7:0] access_addr;
  logic access;
  logic write_access;
  logic read_access;
  logic [15:0] rate;
  logic rate_zero;
  logic fire;
  logic [19:0] amount_used;
  logic [63:0] increment;
  logic [63:0] correction;

  // offset decoders, shared by the write path and the read mux
  function automatic logic hits_amount
  (
    input logic [7:0] addr
  );
    return addr == tod_drift_pkg::amount_offset;
  endfunction

  function automatic logic hits_interval
  (
    input logic [7:0] addr
  );
    return addr == tod_drift_pkg::interval_offset;
  endfunction

  function automatic logic hits_period
  (
    input logic [7:0] addr
  );
    return addr == tod_drift_pkg::period_offset;
  endfunction

  function automatic logic [31:0] read_mux
  (
    input logic [7:0] addr,
    input logic [31:0] amount,
    input logic [31:0] interval,
    input logic [19:0] period
  );
    logic [31:0] value;
    value = tod_drift_pkg::read_zero;
    if (hits_amount(addr))
    begin
      value = {12'h000, amount[tod_drift_pkg::whole_msb:tod_drift_pkg::frac_lsb]};
    end
    else if (hits_interval(addr))
    begin
      value = {16'h0000, interval[tod_drift_pkg::rate_msb:0]};
    end
    else if (hits_period(addr))
    begin
      value = {12'h000, period};
    end
    return value;
  endfunction

  // only the low byte of the address selects a register; higher bits alias
  assign access_addr = haddr[7:0];
  assign access = hsel && hready && htrans[1];
  assign write_access = access && hwrite;
  assign read_access = access && !hwrite;

  always_comb
  begin
    phase_d = phase_idle;
    wr_addr_d = wr_addr_q;
    case (phase_q)
      phase_idle, phase_write, phase_read:
      begin
        // zero wait states: a new address phase may follow any phase at once
        if (write_access)
        begin
          phase_d = phase_write;
          wr_addr_d = access_addr;
        end
        else if (read_access)
        begin
          phase_d = phase_read;
        end
      end
      default:
      begin
        phase_d = phase_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_q <= phase_idle;
      wr_addr_q <= tod_drift_pkg::addr_reset;
    end
    else
    begin
      phase_q <= phase_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  always_comb
  begin
    amount_d = amount_q;
    interval_d = interval_q;
    period_d = period_q;
    case (phase_q)
      phase_write:
      begin
        // write data arrives in the data phase, one cycle after its address
        if (hits_amount(wr_addr_q))
        begin
          amount_d = hwdata;
        end
        else if (hits_interval(wr_addr_q))
        begin
          interval_d = hwdata;
        end
        else if (hits_period(wr_addr_q))
        begin
          period_d = hwdata[tod_drift_pkg::whole_msb:tod_drift_pkg::frac_lsb];
        end
      end
      default:
      begin
        amount_d = amount_q;
        interval_d = interval_q;
        period_d = period_q;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      amount_q <= tod_drift_pkg::amount_reset;
      interval_q <= tod_drift_pkg::interval_reset;
      period_q <= tod_drift_pkg::period_reset;
    end
    else
    begin
      amount_q <= amount_d;
      interval_q <= interval_d;
      period_q <= period_d;
    end
  end

  // reads see a write still in its data phase, so back-to-back write then read is coherent
  always_comb
  begin
    hrdata_d = hrdata_q;
    if (read_access)
    begin
      hrdata_d = read_mux(access_addr, amount_d, interval_d, period_d);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= tod_drift_pkg::read_zero;
    end
    else
    begin
      hrdata_q <= hrdata_d;
    end
  end

  // the slave never stalls and never errs; kept in flops so every output is registered
  always_comb
  begin
    hreadyout_d = tod_drift_pkg::ready_idle;
    hresp_d = tod_drift_pkg::resp_okay;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= tod_drift_pkg::ready_idle;
      hresp_q <= tod_drift_pkg::resp_okay;
    end
    else
    begin
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  assign rate = interval_q[tod_drift_pkg::rate_msb:0];
  assign rate_zero = (rate == tod_drift_pkg::count_reset);
  // a correction is due when the count reaches the rate; rate zero never fires
  assign fire = !rate_zero && (count_q == rate);

  // lowering the rate below the running count makes it wrap through 16 bits first
  always_comb
  begin
    count_d = count_q + tod_drift_pkg::count_one;
    if (fire || rate_zero)
    begin
      count_d = tod_drift_pkg::count_one;
    end
  end

  // all state runs on the period clock with its own active-low reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q <= tod_drift_pkg::count_one;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign amount_used = amount_q[tod_drift_pkg::whole_msb:tod_drift_pkg::frac_lsb];
  assign increment = {44'h0, period_q};
  assign correction = {44'h0, amount_used};

  always_comb
  begin
    tod_d = tod_q + increment;
    if (fire)
    begin
      tod_d = tod_q + increment + correction;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tod_q <= tod_drift_pkg::tod_reset;
    end
    else
    begin
      tod_q <= tod_d;
    end
  end

  // the pulse rises on the same edge that puts the correction into the time value
  always_comb
  begin
    applied_d = fire;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      applied_q <= tod_drift_pkg::pulse_reset;
    end
    else
    begin
      applied_q <= applied_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign time_of_day = tod_q;
  assign correction_applied = applied_q;

endmodule
`default_nettype wire

// ==== tb/tod_drift_asserts.sv ====
/* checker for tod_drift_adjust, bound to its ports.
   assumes the one master issues single word transfers. */
`timescale 1ns/1ns
`default_nettype none
module tod_drift_asserts
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire logic hsel,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // time value
  input wire logic [63:0] time_of_day,
  input wire logic correction_applied
);
  logic w_q, rd;
  logic [7:0] a_q;
  logic [19:0] per_q, amt_q;
  logic [15:0] rate_q;
  assign rd = hsel & hready & htrans[1] & !hwrite;
  // shadow of the writable fields, so steps can be predicted
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {w_q, a_q, per_q, amt_q, rate_q} <= '0;
    else
    begin
      w_q <= hsel & hready & htrans[1] & hwrite;
      a_q <= haddr[7:0];
      if (w_q && a_q == tod_drift_pkg::period_offset) per_q <= hwdata[19:0];
      if (w_q && a_q == tod_drift_pkg::amount_offset) amt_q <= hwdata[19:0];
      if (w_q && a_q == tod_drift_pkg::interval_offset) rate_q <= hwdata[15:0];
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_okay: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
  a_step_plain: assert property (!correction_applied |-> time_of_day - $past(time_of_day) == $past(per_q))
    else $error("plain step is not the period");
  a_step_fix: assert property (correction_applied |->
    time_of_day - $past(time_of_day) == $past(per_q) + $past(amt_q)) else $error("corrected step wrong");
  a_rate_zero: assert property ($past(rate_q) == 16'h0 |-> !correction_applied) else $error("pulse at rate 0");
  a_pulse_restart: assert property (correction_applied && rate_q > 16'h1 |=> !correction_applied)
    else $error("pulses too close");
  a_reset_quiet: assert property ($rose(hresetn) |-> time_of_day == 64'h0 && !correction_applied)
    else $error("state not cleared by reset");
  a_time_rises: assert property (time_of_day >= $past(time_of_day)) else $error("time went back");
  a_read_holds: assert property (!$past(rd) |-> $stable(hrdata)) else $error("read data moved");
  cover property (correction_applied && amt_q[19:16] != 4'h0);
  cover property (correction_applied ##5 correction_applied);
  cover property (rd);
endmodule
bind tod_drift_adjust tod_drift_asserts u_tod_drift_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .correction_applied(correction_applied),
  .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .time_of_day(time_of_day));
`default_nettype wire

// ==== tb/tb_top.sv ====
/* bench for tod_drift_adjust: register access and correction timing.
   assumes a zero-wait slave that always answers okay. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, correction_applied;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [63:0] time_of_day, t0;
  int fails = 0, check_count = 0, cyc = 0;
  tod_drift_adjust u_tod_drift_adjust (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(tod_drift_pkg::hsize_word), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .time_of_day(time_of_day), .correction_applied(correction_applied));
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) if (++cyc > 2000) begin fails++; report_and_stop(); end
  task cmp(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin fails++; $display("BAD %0t got %h exp %h", $time, got, exp); end
  endtask
  // one single transfer; read data taken at the closing edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= tod_drift_pkg::htrans_nonseq;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task t_regs;
    bus(1'h0, tod_drift_pkg::amount_offset, 32'h0); cmp(r, 64'h0);
    bus(1'h0, tod_drift_pkg::interval_offset, 32'h0); cmp(r, 64'h0);
    bus(1'h1, tod_drift_pkg::amount_offset, 32'hfff5_0002); bus(1'h0, tod_drift_pkg::amount_offset, 32'h0);
    cmp(r, 64'h0005_0002);
    bus(1'h1, tod_drift_pkg::interval_offset, 32'habcd_0005); bus(1'h0, tod_drift_pkg::interval_offset, 32'h0);
    cmp(r, 64'h5);
    bus(1'h0, 8'h24, 32'h0); cmp(r, 64'h0);
    $display("register test done");
  endtask
  // amount is added once per five-cycle interval, period on every edge
  task t_fix(input logic [31:0] amt);
    bus(1'h1, tod_drift_pkg::amount_offset, amt);
    do @(posedge hclk); while (correction_applied !== 1'h1);
    t0 = time_of_day;
    repeat (4) begin @(posedge hclk); cmp(correction_applied, 64'h0); end
    @(posedge hclk);
    cmp(correction_applied, 64'h1);
    cmp(time_of_day, t0 + 64'd5 * 64'h6_6666 + amt[19:0]);
    $display("correction test done");
  endtask
  task t_zero;
    bus(1'h1, tod_drift_pkg::interval_offset, 32'hffff_0000);
    repeat (2) @(posedge hclk);
    t0 = time_of_day;
    repeat (20) begin @(posedge hclk); cmp(correction_applied, 64'h0); end
    cmp(time_of_day, t0 + 64'd20 * 64'h6_6666);
    $display("zero rate test done");
  endtask
  // a reset in mid-run clears both correction registers and stops corrections
  task t_reset;
    hresetn <= 1'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    cmp(time_of_day, 64'h0);
    bus(1'h0, tod_drift_pkg::amount_offset, 32'h0);
    cmp(r, 64'h0);
    bus(1'h0, tod_drift_pkg::interval_offset, 32'h0);
    cmp(r, 64'h0);
    repeat (8)
    begin
      @(posedge hclk);
      cmp(correction_applied, 64'h0);
    end
    $display("reset test done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    bus(1'h1, tod_drift_pkg::period_offset, 32'h0006_6666);
    t_fix(32'hfff5_0002);
    t_fix(32'h0000_0002);
    t_zero();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
